// File: rtl/pmu_pkg.sv
package pmu_pkg;
	// Clock and derived rates
	localparam int CLK_HZ = 20_000_000;
	localparam int RTC_HZ = 32768;
	localparam int RTC_DIV = CLK_HZ / RTC_HZ;
	localparam int HANG_TIME_MS = 4000;
	localparam int HANG_CYCLES = HANG_TIME_MS * (CLK_HZ / 1000);
	localparam int CORE_RST_CYCLES = 4;
	localparam int NUM_WAKE = 8;

	// Register indices; byte address is four times the index
	localparam logic [31:0] IDX_STATUS = 32'h0F0000C0;
	localparam logic [31:0] IDX_CTRL = 32'h0F0000C2;
	localparam logic [31:0] IDX_STATUS2 = 32'h0F0000C4;
	localparam logic [31:0] IDX_CTRL2 = 32'h0F0000C6;
	localparam logic [31:0] IDX_WAIT = 32'h0F0000C8;
	localparam logic [31:0] IDX_TDIV = 32'h0F0000CC;
	localparam logic [31:0] IDX_IDIV = 32'h0F0000CE;
	localparam logic [31:0] IDX_MODE = 32'h0F0000D0;

	// wake_reset_status fields
	localparam int STS_PIN0 = 12;
	localparam int STS_CLOCK_RUN_INPUT = 11;
	localparam int STS_DCD = 10;
	localparam int STS_ALARM = 9;
	localparam int STS_BATTERY_INHIBIT_FLAG = 8;
	localparam int STS_HANG = 5;
	localparam int STS_RTC = 4;
	localparam int STS_RESET_SWITCH_INPUT = 3;
	localparam int STS_BATTLOW = 1;
	localparam int STS_PWRSW = 0;
	localparam logic [15:0] STS_W1C = 16'hFB3B;
	localparam logic [15:0] STS_MEMO = 16'h00C0;

	// power_control fields
	localparam int CTL_EN0 = 12;
	localparam int CTL_TRG0 = 8;
	localparam int CTL_PLLOFF = 3;
	localparam int CTL_HANGCLR = 2;
	localparam logic [15:0] CTL_RW = 16'hFF8C;
	localparam logic [15:0] CTL_ONE = 16'h0002;

	// Upper pin registers
	localparam int ST2_PIN9 = 12;
	localparam logic [15:0] ST2_W1C = 16'hF000;
	localparam int CT2_EN9 = 12;
	localparam int CT2_TRG9 = 8;
	localparam int CT2_SOFTWARE_RESET_BIT = 4;
	localparam logic [15:0] CT2_RW = 16'hFF10;
	localparam logic [15:0] WAIT_RW = 16'h3FFF;
	localparam logic [15:0] TDIV_RW = 16'h0107;
	localparam logic [15:0] IDIV_RW = 16'h0007;

	// Values after an RTC-domain reset
	localparam logic [15:0] STS_INIT = 16'h0010;
	localparam logic [15:0] CTL_INIT = 16'h8802;
	localparam logic [15:0] CT2_INIT = 16'h0000;
	localparam logic [15:0] WAIT_INIT = 16'h2C00;
	localparam logic [15:0] DIV_INIT = 16'h0000;

	typedef enum logic [3:0] {
		MODE_RUN,
		MODE_STBY_WAIT,
		MODE_STANDBY,
		MODE_SUSP_WAIT,
		MODE_SUSPEND,
		MODE_DEEP_SUSPEND,
		MODE_HIB_WAIT,
		MODE_HIBERNATE,
		MODE_POWER_WAIT,
		MODE_CORE_RESET
	} mode_t;
endpackage

// File: rtl/wake_edge_detect.sv
`timescale 1ns/1ps
module wake_edge_detect #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleEn,
	input wire logic [WIDTH-1:0] pinLevel,
	input wire logic [WIDTH-1:0] fallSel,
	output logic [WIDTH-1:0] edgeHit
);
	typedef struct packed {
		logic primed;
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] hit;
	} edge_t;
	edge_t st;
	edge_t next_st;

	// First sample only primes, so reset cannot fake a rising edge
	always_comb begin
		next_st = st;
		next_st.hit = '0;
		if (sampleEn) begin
			next_st.prev = pinLevel;
			next_st.primed = 1'b1;
			if (st.primed) begin
				next_st.hit = (fallSel & st.prev & ~pinLevel) |
					(~fallSel & ~st.prev & pinLevel);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign edgeHit = st.hit;
endmodule

// File: rtl/hang_timer.sv
`timescale 1ns/1ps
module hang_timer #(
	parameter int COUNT = 80_000_000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic clear,
	output logic expired
);
	localparam int CW = $clog2(COUNT + 1);
	typedef struct packed {
		logic running;
		logic [CW-1:0] cnt;
		logic fired;
	} hang_t;
	hang_t st;
	hang_t next_st;

	// One shot per arming; a clear stops it for good until rearmed
	always_comb begin
		next_st = st;
		next_st.fired = 1'b0;
		if (arm) begin
			next_st.running = 1'b1;
			next_st.cnt = '0;
		end else if (clear) begin
			next_st.running = 1'b0;
		end else if (st.running) begin
			if (st.cnt == CW'(COUNT - 1)) begin
				next_st.running = 1'b0;
				next_st.fired = 1'b1;
			end else begin
				next_st.cnt = st.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign expired = st.fired;
endmodule

// File: rtl/power_mode_and_wake_status_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - RTC reset works always, never restarts core
// - Standby: wait bus idle, hold pipeline clock
// - Any interrupt ends standby
// - Suspend: wait idle and self-refresh, stop bus
// - Peripheral interrupt or reset ends suspend
// - PLL-stop enable turns suspend into deep
// - Hibernate: also drop main power, stop PLL
// - Alarm, switch, carrier, wake pin end hibernate
// - Hibernate wake keeps this unit's registers
// - Wake pins configured here, RTC-rate edges
// - Pin 3 falling wakes right after RTC reset
// - Outside hibernate pins go synced to interrupts
// - Flags clear by writing one, zero ignored
// - Carrier level bit shows live pin level
// - Battery low at power-on sets inhibit flag
// - Battery falling outside hibernate sets low flag
// - Power switch rise flagged only outside hibernate
// - Clock-run low flagged only in suspend
// - Reset-switch flag set by switch or software
// - RTC reset sets its flag, clears most others
// - Two memo bits free, kept across core resets, cleared by RTC reset
// - Enable bit allows wake, trigger picks edge
// - RTC reset enables pin 3 falling only
// - Hang timer must be cleared within four seconds
// - Wake pin activation counts only in hibernate
module power_mode_and_wake_status_unit #(
	parameter int HANG_CYCLES = pmu_pkg::HANG_CYCLES,
	parameter int RTC_DIV = pmu_pkg::RTC_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic rtcDomainReset,
	input wire logic standbyRequest,
	input wire logic suspendRequest,
	input wire logic hibernateRequest,
	input wire logic busIdle,
	input wire logic selfRefreshAck,
	input wire logic anyInterrupt,
	input wire logic peripheralInterrupt,
	input wire logic rtcAlarm,
	input wire logic powerSwitch,
	input wire logic carrierDetect_n,
	input wire logic batteryInhibit_n,
	input wire logic clockRun_n,
	input wire logic resetSwitch,
	input wire logic [pmu_pkg::NUM_WAKE-1:0] wakePin,
	output logic [pmu_pkg::NUM_WAKE-1:0] wakePinSync,
	output logic pipelineClockHold,
	output logic busClockStop,
	output logic intClockStop,
	output logic pllStop,
	output logic mainPower,
	output logic powerOn,
	output logic selfRefreshReq,
	output logic coreReset,
	output logic peripheralReset,
	output logic batteryLowIrq
);
	localparam int NW = pmu_pkg::NUM_WAKE;

	typedef struct packed {
		pmu_pkg::mode_t mode;
		logic [15:0] status;
		logic [15:0] ctrl;
		logic [15:0] status2;
		logic [15:0] ctrl2;
		logic [15:0] waitCnt;
		logic [15:0] tdiv;
		logic [15:0] idiv;
		logic ack;
		logic [15:0] rdata;
		logic [9:0] rtcDiv;
		logic [13:0] onWait;
		logic [2:0] rstCnt;
		logic hangArm;
		logic [NW-1:0] pinMeta;
		logic [NW-1:0] pinSync;
		logic battPrev;
		logic pwrPrev;
		logic clkRunPrev;
		logic dcdPrev;
		logic rstSwPrev;
	} unit_t;
	unit_t st;
	unit_t next_st;

	logic busReq;
	logic mapped;
	logic we;
	logic [31:0] regIndex;
	logic [15:0] wd;
	logic [15:0] wm;
	logic [15:0] rdVal;
	logic [15:0] setSts;
	logic [15:0] clrSts;
	logic [15:0] setSt2;
	logic [15:0] clrSt2;
	logic rtcTick;
	logic inHib;
	logic battFall;
	logic pwrRise;
	logic dcdFall;
	logic clkRunFall;
	logic rstEvent;
	logic swReset;
	logic hangClear;
	logic hangExpired;
	logic wakeNow;
	logic [NW-1:0] pinEnable;
	logic [NW-1:0] pinFall;
	logic [NW-1:0] pinHit;
	logic [NW-1:0] pinWake;

	// Flag with set winning over a software clear
	function automatic logic [15:0] w1c(input logic [15:0] old,
		input logic [15:0] set, input logic [15:0] clr);
		w1c = (old & ~clr) | set;
	endfunction

	// Replace only the bits selected by mask
	function automatic logic [15:0] maskWrite(input logic [15:0] old,
		input logic [15:0] data, input logic [15:0] mask);
		maskWrite = (old & ~mask) | (data & mask);
	endfunction

	// Pin order is {12..9, 3..0}
	assign pinEnable = {st.ctrl2[pmu_pkg::CT2_EN9 +: 4],
		st.ctrl[pmu_pkg::CTL_EN0 +: 4]};
	assign pinFall = {st.ctrl2[pmu_pkg::CT2_TRG9 +: 4],
		st.ctrl[pmu_pkg::CTL_TRG0 +: 4]};

	// Wake edges are looked at on the RTC-rate tick only
	wake_edge_detect #(
		.WIDTH(NW)
	) u_wake_edge (
		.clk(clk),
		.rst_n(rst_n),
		.sampleEn(rtcTick),
		.pinLevel(st.pinSync),
		.fallSel(pinFall),
		.edgeHit(pinHit)
	);

	hang_timer #(
		.COUNT(HANG_CYCLES)
	) u_hang (
		.clk(clk),
		.rst_n(rst_n),
		.arm(st.hangArm),
		.clear(hangClear),
		.expired(hangExpired)
	);

	// Avalon slave: one wait cycle, then answer
	assign busReq = read | write;
	assign waitrequest = busReq & ~st.ack;
	assign regIndex = {2'b00, address[31:2]};
	assign we = write & st.ack & mapped;
	assign wd = writedata[15:0];
	assign wm = {{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign rtcTick = (st.rtcDiv == 10'(RTC_DIV - 1));
	assign inHib = st.mode inside {pmu_pkg::MODE_HIBERNATE,
		pmu_pkg::MODE_POWER_WAIT};

	// Input events, each from a registered previous level; software reset and hang clear come from bus writes
	assign battFall = st.battPrev & ~batteryInhibit_n;
	assign pwrRise = ~st.pwrPrev & powerSwitch;
	assign dcdFall = st.dcdPrev & ~carrierDetect_n;
	assign clkRunFall = st.clkRunPrev & ~clockRun_n;
	assign swReset = we & (regIndex == pmu_pkg::IDX_CTRL2) &
		wm[pmu_pkg::CT2_SOFTWARE_RESET_BIT] & wd[pmu_pkg::CT2_SOFTWARE_RESET_BIT];
	assign rstEvent = (~st.rstSwPrev & resetSwitch) | swReset;
	assign hangClear = we & (regIndex == pmu_pkg::IDX_CTRL) &
		wm[pmu_pkg::CTL_HANGCLR] & wd[pmu_pkg::CTL_HANGCLR];
	// Pin activation counts only while hibernating
	assign pinWake = pinHit & pinEnable &
		{NW{st.mode == pmu_pkg::MODE_HIBERNATE}};
	assign wakeNow = rtcAlarm | pwrRise | dcdFall | (|pinWake);

	// Read decode; carrier bit is the live level, never stored
	always_comb begin
		mapped = (address[1:0] == 2'b00);
		rdVal = 16'h0000;
		unique case (regIndex)
			pmu_pkg::IDX_STATUS: begin
				rdVal = st.status;
				rdVal[pmu_pkg::STS_DCD] = st.dcdPrev;
			end
			pmu_pkg::IDX_CTRL: rdVal = st.ctrl | pmu_pkg::CTL_ONE;
			pmu_pkg::IDX_STATUS2: rdVal = st.status2;
			pmu_pkg::IDX_CTRL2: rdVal = st.ctrl2;
			pmu_pkg::IDX_WAIT: rdVal = st.waitCnt;
			pmu_pkg::IDX_TDIV: rdVal = st.tdiv;
			pmu_pkg::IDX_IDIV: rdVal = st.idiv;
			pmu_pkg::IDX_MODE: rdVal = {12'h000, st.mode};
			default: mapped = 1'b0;
		endcase
		if (!mapped) begin
			rdVal = 16'h0000;
		end
	end

	// Mode machine, flags and register writes
	always_comb begin
		next_st = st;
		setSts = 16'h0000;
		setSt2 = 16'h0000;
		clrSts = 16'h0000;
		clrSt2 = 16'h0000;
		next_st.ack = busReq & ~st.ack;
		if (busReq & ~st.ack) begin
			next_st.rdata = rdVal;
		end
		next_st.rtcDiv = rtcTick ? 10'h000 : st.rtcDiv + 10'h001;
		next_st.pinMeta = wakePin;
		next_st.pinSync = st.pinMeta;
		next_st.battPrev = batteryInhibit_n;
		next_st.pwrPrev = powerSwitch;
		next_st.clkRunPrev = clockRun_n;
		next_st.dcdPrev = carrierDetect_n;
		next_st.rstSwPrev = resetSwitch;
		next_st.hangArm = 1'b0;

		// Event flags
		if (battFall && !inHib) begin
			setSts[pmu_pkg::STS_BATTLOW] = 1'b1;
		end
		if (pwrRise && !inHib) begin
			setSts[pmu_pkg::STS_PWRSW] = 1'b1;
		end
		if (clkRunFall && st.mode inside {pmu_pkg::MODE_SUSPEND,
			pmu_pkg::MODE_DEEP_SUSPEND}) begin
			setSts[pmu_pkg::STS_CLOCK_RUN_INPUT] = 1'b1;
		end
		if (rtcAlarm) begin
			setSts[pmu_pkg::STS_ALARM] = 1'b1;
		end
		setSts[pmu_pkg::STS_PIN0 +: 4] = pinWake[3:0];
		setSt2[pmu_pkg::ST2_PIN9 +: 4] = pinWake[7:4];

		// Requested low-power entry only from run
		unique case (st.mode)
			pmu_pkg::MODE_RUN: begin
				if (standbyRequest) begin
					next_st.mode = pmu_pkg::MODE_STBY_WAIT;
				end else if (suspendRequest) begin
					next_st.mode = pmu_pkg::MODE_SUSP_WAIT;
				end else if (hibernateRequest) begin
					next_st.mode = pmu_pkg::MODE_HIB_WAIT;
				end
			end
			pmu_pkg::MODE_STBY_WAIT: begin
				if (busIdle) begin
					next_st.mode = pmu_pkg::MODE_STANDBY;
				end
			end
			pmu_pkg::MODE_STANDBY: begin
				if (anyInterrupt) begin
					next_st.mode = pmu_pkg::MODE_RUN;
				end
			end
			pmu_pkg::MODE_SUSP_WAIT: begin
				if (busIdle && selfRefreshAck) begin
					next_st.mode = st.ctrl[pmu_pkg::CTL_PLLOFF] ?
						pmu_pkg::MODE_DEEP_SUSPEND :
						pmu_pkg::MODE_SUSPEND;
				end
			end
			pmu_pkg::MODE_SUSPEND, pmu_pkg::MODE_DEEP_SUSPEND: begin
				if (peripheralInterrupt || clkRunFall) begin
					next_st.mode = pmu_pkg::MODE_RUN;
				end
			end
			pmu_pkg::MODE_HIB_WAIT: begin
				if (busIdle && selfRefreshAck) begin
					next_st.mode = pmu_pkg::MODE_HIBERNATE;
				end
			end
			pmu_pkg::MODE_HIBERNATE: begin
				if (wakeNow) begin
					next_st.mode = pmu_pkg::MODE_POWER_WAIT;
					next_st.onWait = 14'h0000;
				end
			end
			pmu_pkg::MODE_POWER_WAIT: begin
				// Wait (count + 1) RTC ticks, then check the battery
				if (rtcTick) begin
					if (st.onWait == st.waitCnt[13:0]) begin
						if (!batteryInhibit_n) begin
							setSts[pmu_pkg::STS_BATTERY_INHIBIT_FLAG] = 1'b1;
							next_st.mode = pmu_pkg::MODE_HIBERNATE;
						end else begin
							next_st.mode = pmu_pkg::MODE_CORE_RESET;
							next_st.rstCnt = 3'h0;
						end
					end else begin
						next_st.onWait = st.onWait + 14'h0001;
					end
				end
			end
			pmu_pkg::MODE_CORE_RESET: begin
				// Registers here survive the restart, except the software reset bit
				if (st.rstCnt == 3'(pmu_pkg::CORE_RST_CYCLES - 1)) begin
					next_st.mode = pmu_pkg::MODE_RUN;
					next_st.hangArm = 1'b1;
					next_st.ctrl2[pmu_pkg::CT2_SOFTWARE_RESET_BIT] = 1'b0;
				end else begin
					next_st.rstCnt = st.rstCnt + 3'h1;
				end
			end
		endcase

		// Reset switch is no wake source from hibernate
		if (rstEvent && !inHib) begin
			next_st.mode = pmu_pkg::MODE_CORE_RESET;
			next_st.rstCnt = 3'h0;
			setSts[pmu_pkg::STS_RESET_SWITCH_INPUT] = 1'b1;
		end
		// A runaway program is shut down
		if (hangExpired) begin
			next_st.mode = pmu_pkg::MODE_HIBERNATE;
			setSts[pmu_pkg::STS_HANG] = 1'b1;
		end

		// Software writes
		if (we && regIndex == pmu_pkg::IDX_STATUS) begin
			clrSts = wd & wm & pmu_pkg::STS_W1C;
			next_st.status = maskWrite(st.status, wd,
				wm & pmu_pkg::STS_MEMO);
		end
		if (we && regIndex == pmu_pkg::IDX_STATUS2) begin
			clrSt2 = wd & wm & pmu_pkg::ST2_W1C;
		end
		next_st.status = w1c(next_st.status, setSts, clrSts);
		next_st.status2 = w1c(st.status2, setSt2, clrSt2);
		if (we && regIndex == pmu_pkg::IDX_CTRL) begin
			next_st.ctrl = maskWrite(st.ctrl, wd, wm & pmu_pkg::CTL_RW);
		end
		if (we && regIndex == pmu_pkg::IDX_CTRL2) begin
			next_st.ctrl2 = maskWrite(st.ctrl2, wd, wm & pmu_pkg::CT2_RW);
		end
		if (we && regIndex == pmu_pkg::IDX_WAIT) begin
			next_st.waitCnt = maskWrite(st.waitCnt, wd,
				wm & pmu_pkg::WAIT_RW);
		end
		if (we && regIndex == pmu_pkg::IDX_TDIV) begin
			next_st.tdiv = maskWrite(st.tdiv, wd, wm & pmu_pkg::TDIV_RW);
		end
		if (we && regIndex == pmu_pkg::IDX_IDIV) begin
			next_st.idiv = maskWrite(st.idiv, wd, wm & pmu_pkg::IDIV_RW);
		end

		// RTC-domain reset: registers only, the core keeps running
		if (rtcDomainReset) begin
			next_st.status = pmu_pkg::STS_INIT |
				(st.status & 16'(1 << pmu_pkg::STS_RESET_SWITCH_INPUT));
			next_st.ctrl = pmu_pkg::CTL_INIT;
			next_st.ctrl2 = pmu_pkg::CT2_INIT;
			next_st.status2 = 16'h0000;
			next_st.waitCnt = pmu_pkg::WAIT_INIT;
			next_st.tdiv = pmu_pkg::DIV_INIT;
			next_st.idiv = pmu_pkg::DIV_INIT;
		end
	end

	// Power-on reset equals an RTC-domain reset of the registers, except that it also clears the reset-switch flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.mode <= pmu_pkg::MODE_RUN;
			st.status <= pmu_pkg::STS_INIT;
			st.ctrl <= pmu_pkg::CTL_INIT;
			st.waitCnt <= pmu_pkg::WAIT_INIT;
			st.hangArm <= 1'b1;
			st.battPrev <= 1'b1;
			st.clkRunPrev <= 1'b1;
			st.dcdPrev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Clock and power controls decoded from the registered mode
	assign pipelineClockHold = (st.mode != pmu_pkg::MODE_RUN);
	assign busClockStop = st.mode inside {pmu_pkg::MODE_SUSPEND,
		pmu_pkg::MODE_DEEP_SUSPEND, pmu_pkg::MODE_HIBERNATE,
		pmu_pkg::MODE_POWER_WAIT};
	assign intClockStop = inHib;
	assign pllStop = inHib || st.mode == pmu_pkg::MODE_DEEP_SUSPEND;
	assign mainPower = ~inHib || st.mode == pmu_pkg::MODE_POWER_WAIT;
	assign powerOn = (st.mode == pmu_pkg::MODE_POWER_WAIT);
	assign selfRefreshReq = st.mode inside {pmu_pkg::MODE_SUSP_WAIT,
		pmu_pkg::MODE_SUSPEND, pmu_pkg::MODE_DEEP_SUSPEND,
		pmu_pkg::MODE_HIB_WAIT, pmu_pkg::MODE_HIBERNATE,
		pmu_pkg::MODE_POWER_WAIT};
	assign coreReset = (st.mode == pmu_pkg::MODE_CORE_RESET);
	assign peripheralReset = inHib || coreReset;
	assign batteryLowIrq = st.status[pmu_pkg::STS_BATTLOW];
	assign wakePinSync = st.pinSync;
	assign readdata = {16'h0000, st.rdata};
endmodule

// File: tb/core_bus_model.sv
`timescale 1ns/1ps
module core_bus_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] lat,
	input wire logic pipelineClockHold,
	input wire logic selfRefreshReq,
	output logic busIdle,
	output logic selfRefreshAck
);
	logic [4:0] held;

	// Bus drains lat cycles after the pipeline stops; DRAM enters self
	// refresh two cycles later still, so the unit is never told early
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held <= 5'h00;
			busIdle <= 1'b0;
			selfRefreshAck <= 1'b0;
		end else begin
			held <= !pipelineClockHold ? 5'h00 :
				(held == 5'h1F ? held : held + 5'h01);
			busIdle <= pipelineClockHold && held >= {1'b0, lat};
			selfRefreshAck <= selfRefreshReq &&
				held >= {1'b0, lat} + 5'h02;
		end
	end
endmodule

// File: tb/pmu_properties.sv
`timescale 1ns/1ps
module pmu_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic busIdle,
	input wire logic selfRefreshAck,
	input wire logic anyInterrupt,
	input wire logic rtcDomainReset,
	input wire logic resetSwitch,
	input wire logic pipelineClockHold,
	input wire logic selfRefreshReq,
	input wire logic busClockStop,
	input wire logic intClockStop,
	input wire logic pllStop,
	input wire logic mainPower,
	input wire logic powerOn,
	input wire logic coreReset,
	input wire logic batteryLowIrq
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// The bus clock may only stop, and main power drop, once bus and DRAM have both settled
	sequence hand_off;
		$past(busIdle && selfRefreshAck);
	endsequence
	// Core reset lasts four cycles and hands back to run mode
	sequence core_pulse;
		coreReset [*4] ##1 (!coreReset && !pipelineClockHold);
	endsequence

	AST_RTC_NO_CORE: assert property (
		rtcDomainReset && !coreReset && !resetSwitch |=> !coreReset)
		else $error("rtc reset restarted the core");
	AST_STBY_WAKE: assert property (
		pipelineClockHold && !selfRefreshReq && !coreReset &&
		anyInterrupt |=> !pipelineClockHold)
		else $error("interrupt did not end standby");
	AST_SUSP_ENTRY: assert property (
		$rose(busClockStop) |-> hand_off)
		else $error("bus clock stopped before hand-off");
	AST_DEEP_BUS: assert property (
		pllStop |-> busClockStop && pipelineClockHold)
		else $error("pll stopped with bus clock running");
	AST_HIB_ENTRY: assert property (
		$fell(mainPower) |-> hand_off)
		else $error("main power dropped before hand-off");
	AST_HIB_CLOCKS: assert property (
		!mainPower |-> pllStop && intClockStop && busClockStop &&
		!powerOn)
		else $error("clock left running in hibernate");
	AST_WAKE_POWER: assert property (
		$rose(mainPower) |-> powerOn && pllStop)
		else $error("wake skipped the power-on wait");
	AST_BATT_LOW: assert property (
		$rose(batteryLowIrq) |-> $past(mainPower))
		else $error("battery low raised in hibernate");
	AST_CORE_RESET: assert property (
		$rose(coreReset) |-> core_pulse)
		else $error("core reset pulse malformed");
	AST_LP_FROM_RUN: assert property (
		$rose(selfRefreshReq) |-> !$past(pipelineClockHold))
		else $error("low-power entry outside run mode");
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] ST = pmu_pkg::IDX_STATUS;
	localparam logic [31:0] CT = pmu_pkg::IDX_CTRL;
	localparam logic [31:0] WT = pmu_pkg::IDX_WAIT;
	localparam logic [31:0] MD = pmu_pkg::IDX_MODE;
	logic clk, rst_n, read, write, waitrequest;
	logic [31:0] address, writedata, readdata;
	logic [3:0] byteenable, lat;
	logic [4:0] pulses;
	logic busIdle, selfRefreshAck, anyInterrupt, peripheralInterrupt;
	logic powerSwitch, carrierDetect_n, batteryInhibit_n, clockRun_n;
	logic resetSwitch, pipelineClockHold, busClockStop, intClockStop;
	logic pllStop, mainPower, powerOn, selfRefreshReq, coreReset;
	logic peripheralReset, batteryLowIrq;
	logic [pmu_pkg::NUM_WAKE-1:0] wakePin, wakePinSync;
	logic [15:0] rd, sts, r;
	logic [31:0] seed;
	logic [31:0] idx [4];
	logic [15:0] msk [4];
	int fails = 0;
	int compares = 0;
	int cycles = 0;

	// Short counts keep the power-on wait and hang timer within the run
	power_mode_and_wake_status_unit #(.HANG_CYCLES(3000),
		.RTC_DIV(4)) u_dut (
		.clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .rtcDomainReset(pulses[4]),
		.standbyRequest(pulses[0]), .suspendRequest(pulses[1]),
		.hibernateRequest(pulses[2]), .busIdle, .selfRefreshAck,
		.anyInterrupt, .peripheralInterrupt, .rtcAlarm(pulses[3]),
		.powerSwitch, .carrierDetect_n, .batteryInhibit_n, .clockRun_n,
		.resetSwitch, .wakePin, .wakePinSync, .pipelineClockHold,
		.busClockStop, .intClockStop, .pllStop, .mainPower, .powerOn,
		.selfRefreshReq, .coreReset, .peripheralReset, .batteryLowIrq);
	core_bus_model u_core (.clk, .rst_n, .lat, .pipelineClockHold,
		.selfRefreshReq, .busIdle, .selfRefreshAck);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Carrier bit is a live level, not a flag, so it is patched in
	function automatic logic [15:0] stsExp(input logic [15:0] f,
		input logic d);
		return (f & 16'hFBFF) | {5'h00, d, 10'h000};
	endfunction

	task automatic report_and_stop;
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until a rising edge sees waitrequest low; data taken
	// at that edge, which is also the edge a write lands on
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [15:0] d);
		@(posedge clk);
		address <= {a[29:0], 2'b00};
		read <= !w;
		write <= w;
		writedata <= {16'h0000, d};
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata[15:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000);
		chk(rd, exp);
	endtask
	task automatic wait_reg(input logic [31:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 16'h0000);
			n++;
		end while ((rd & m) !== exp && n < 300);
		chk(rd & m, exp);
	endtask
	task automatic wait_mode(input logic [3:0] m);
		wait_reg(MD, 16'h000F, {12'h000, m});
	endtask
	// One-cycle pulse; the partner's latency is redrawn each time
	task automatic pulse(input int b);
		seed = xs(seed);
		lat <= {1'b0, seed[2:0]};
		@(posedge clk) pulses[b] <= 1'b1;
		@(posedge clk) pulses[b] <= 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// A hung handshake ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			report_and_stop;
		end
	end

	initial begin
		{rst_n, read, write, anyInterrupt, peripheralInterrupt} = 5'h00;
		{powerSwitch, resetSwitch, pulses, lat} = 11'h000;
		{carrierDetect_n, batteryInhibit_n, clockRun_n} = 3'h7;
		address = 32'h00000000;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		wakePin = '1;
		seed = 32'h95D519C4;
		idx = '{ST, WT, pmu_pkg::IDX_TDIV, pmu_pkg::IDX_IDIV};
		msk = '{pmu_pkg::STS_MEMO, pmu_pkg::WAIT_RW, pmu_pkg::TDIV_RW,
			pmu_pkg::IDIV_RW};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(ST, 16'h0410);
		rdchk(CT, pmu_pkg::CTL_INIT);
		rdchk(32'h0F0000D4, 16'h0000);
		bus(1'b1, ST, 16'h0000);
		rdchk(ST, 16'h0410);
		bus(1'b1, ST, 16'h0010);
		rdchk(ST, 16'h0400);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			r = seed[15:0];
			bus(1'b1, idx[i % 4], r);
			rdchk(idx[i % 4], (r & msk[i % 4]) |
				((i % 4 == 0) ? 16'h0400 : 16'h0000));
		end
		sts = 16'h00C0;
		bus(1'b1, ST, sts);
		bus(1'b1, WT, 16'h0005);
		// Run-mode events: switch and battery flag, clock-run ignored
		@(posedge clk) powerSwitch <= 1'b1;
		@(posedge clk) batteryInhibit_n <= 1'b0;
		@(posedge clk) clockRun_n <= 1'b0;
		pulse(3);
		repeat (4) @(posedge clk);
		powerSwitch <= 1'b0;
		batteryInhibit_n <= 1'b1;
		clockRun_n <= 1'b1;
		rdchk(ST, stsExp(sts | 16'h0203, 1'b1));
		chk({15'h0000, batteryLowIrq}, 16'h0001);
		bus(1'b1, ST, sts | 16'h0203);
		rdchk(ST, stsExp(sts, 1'b1));
		chk({15'h0000, batteryLowIrq}, 16'h0000);
		// Standby, suspend and deep suspend round trips
		pulse(0);
		wait_mode(4'h2);
		chk({14'h0000, pipelineClockHold, busClockStop}, 16'h0002);
		@(posedge clk) anyInterrupt <= 1'b1;
		wait_mode(4'h0);
		anyInterrupt <= 1'b0;
		pulse(1);
		wait_mode(4'h4);
		chk({14'h0000, busClockStop, pllStop}, 16'h0002);
		@(posedge clk) clockRun_n <= 1'b0;
		wait_mode(4'h0);
		clockRun_n <= 1'b1;
		sts = sts | 16'h0800;
		bus(1'b1, CT, 16'h880A);
		rdchk(CT, 16'h880A);
		pulse(1);
		wait_mode(4'h5);
		chk({15'h0000, pllStop}, 16'h0001);
		@(posedge clk) peripheralInterrupt <= 1'b1;
		wait_mode(4'h0);
		peripheralInterrupt <= 1'b0;
		bus(1'b1, CT, 16'h8802);
		// Hibernate ended by the power switch, which sets no flag then
		pulse(2);
		wait_mode(4'h7);
		chk({14'h0000, mainPower, peripheralReset}, 16'h0001);
		@(posedge clk) powerSwitch <= 1'b1;
		wait_mode(4'h0);
		powerSwitch <= 1'b0;
		rdchk(ST, stsExp(sts, 1'b1));
		// Pin edge in run mode only reaches the synchroniser
		@(posedge clk) wakePin[3] <= 1'b0;
		repeat (20) @(posedge clk);
		chk({8'h00, wakePinSync}, {8'h00, wakePin});
		rdchk(ST, stsExp(sts, 1'b1));
		@(posedge clk) wakePin[3] <= 1'b1;
		repeat (20) @(posedge clk);
		// Weak battery refuses the carrier wake; pin 3 then succeeds
		pulse(2);
		wait_mode(4'h7);
		@(posedge clk) batteryInhibit_n <= 1'b0;
		@(posedge clk) carrierDetect_n <= 1'b0;
		wait_reg(ST, 16'h0100, 16'h0100);
		wait_mode(4'h7);
		batteryInhibit_n <= 1'b1;
		repeat (8) @(posedge clk);
		wakePin[3] <= 1'b0;
		wait_mode(4'h0);
		sts = sts | 16'h8100;
		rdchk(ST, stsExp(sts, 1'b0));
		// Switch and software resets both mark the reset-switch flag
		@(posedge clk) resetSwitch <= 1'b1;
		wait_reg(ST, 16'h0008, 16'h0008);
		wait_mode(4'h0);
		resetSwitch <= 1'b0;
		rdchk(ST, stsExp(sts | 16'h0008, 1'b0));
		bus(1'b1, ST, 16'h0008);
		bus(1'b1, pmu_pkg::IDX_CTRL2, 16'h0010);
		wait_reg(ST, 16'h0008, 16'h0008);
		wait_mode(4'h0);
		pulse(4);
		repeat (2) @(posedge clk);
		rdchk(ST, 16'h0018);
		rdchk(CT, pmu_pkg::CTL_INIT);
		rdchk(WT, pmu_pkg::WAIT_INIT);
		rdchk(MD, 16'h0000);
		// Timer was rearmed by the soft reset; a clear must stop it
		bus(1'b1, CT, 16'h8806);
		repeat (3100) @(posedge clk);
		rdchk(MD, 16'h0000);
		report_and_stop;
	end
endmodule

bind power_mode_and_wake_status_unit pmu_properties u_props (
	.clk, .rst_n, .busIdle, .selfRefreshAck, .anyInterrupt,
	.rtcDomainReset, .resetSwitch, .pipelineClockHold, .selfRefreshReq,
	.busClockStop, .intClockStop, .pllStop, .mainPower, .powerOn,
	.coreReset, .batteryLowIrq);
